// ==== rtl/twrs_pkg.sv ====
// Shared constants for the two-wire register slave and its bus master
package twrs_pkg;
	// Register space of the slave
	localparam int REG_COUNT = 128;
	localparam logic [6:0] PTR_RESET = 7'h00;
	localparam logic [6:0] PTR_MAX = 7'h7F;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [6:0] TUNER_PORT_ADDR = 7'h14;
	localparam int TUNER_PASS_BIT = 6;
	localparam int INHIBIT_BIT = 7;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] STRAP_LATCH_CNT = 2'h2;
	localparam logic [1:0] STRAP_DONE_CNT = 2'h3;

	// Timing of the clock the master makes
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_CYCLES_INT = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYCLES_INT - 1);

	// Master command registers (byte addresses)
	localparam logic [3:0] CMD_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_ACK_BIT = 3;
	localparam int CMD_DATA_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NACK_BIT = 1;
	localparam int STAT_DATA_LSB = 8;
	localparam logic [2:0] CMD_START = 3'h1;
	localparam logic [2:0] CMD_STOP = 3'h2;
	localparam logic [2:0] CMD_WRITE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h4;
endpackage

// ==== rtl/twrs_if.sv ====
// Open-drain primary and secondary two-wire pins between the parties
`timescale 1ns/1ps
interface twrs_if;
	logic scl_m_oe;
	logic sda_m_oe;
	logic sda_d_oe;
	logic sscl_d_oe;
	logic ssda_d_oe;
	logic ssda_t_oe;
	logic primary_serial_clock;
	logic primary_serial_data;
	logic secondary_serial_clock;
	logic secondary_serial_data;

	// Pull-ups: a line is high unless someone pulls it low
	assign primary_serial_clock = !scl_m_oe;
	assign primary_serial_data = !(sda_m_oe || sda_d_oe);
	assign secondary_serial_clock = !sscl_d_oe;
	assign secondary_serial_data = !(ssda_d_oe || ssda_t_oe);

	modport device(
		input primary_serial_clock,
		input primary_serial_data,
		input secondary_serial_data,
		output sda_d_oe,
		output sscl_d_oe,
		output ssda_d_oe
	);
	modport master(
		input primary_serial_clock,
		input primary_serial_data,
		output scl_m_oe,
		output sda_m_oe
	);
	modport tuner(
		input secondary_serial_clock,
		input secondary_serial_data,
		output ssda_t_oe
	);
endinterface

// ==== rtl/twrs_device.sv ====
// Register-access slave on the primary two-wire bus with tuner pass-through
`timescale 1ns/1ps
module twrs_device(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [6:0] bus_addr_i,
	twrs_if.device link,
	output logic pass_enable_o,
	output logic wr_pulse_o,
	output logic [6:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic [6:0] own_addr_o
);
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_SUB, S_SUB_ACK,
		S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK, S_IGNORE
	} twrs_dstate_type;

	twrs_dstate_type state;
	logic [1:0] scl_sy;
	logic [1:0] sda_sy;
	logic [1:0] ssda_sy;
	logic scl_q;
	logic sda_q;
	logic [6:0] addr_s1;
	logic [6:0] addr_s2;
	logic [1:0] strap_cnt;
	logic [7:0] regs [0:twrs_pkg::REG_COUNT-1];
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [3:0] bitcnt;
	logic [6:0] ptr;
	logic inhibit;
	logic rw;
	logic msg_active;
	logic resumed;
	logic sda_drv;
	logic pull_p;
	logic pull_s;
	logic [5:0] echo_hist;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	// Next pointer after one byte: hold, saturate or step
	function automatic logic [6:0] next_ptr(input logic [6:0] p, input logic inh);
		if (inh) begin
			next_ptr = p;
		end else if (p == twrs_pkg::PTR_MAX) begin
			next_ptr = p;
		end else begin
			next_ptr = p + 7'h01;
		end
	endfunction

	// Pins are asynchronous to clk_i
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			ssda_sy <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sy <= {scl_sy[0], link.primary_serial_clock};
			sda_sy <= {sda_sy[0], link.primary_serial_data};
			ssda_sy <= {ssda_sy[0], link.secondary_serial_data};
			scl_q <= scl_sy[1];
			sda_q <= sda_sy[1];
		end
	end

	assign scl_rise = scl_sy[1] && !scl_q;
	assign scl_fall = !scl_sy[1] && scl_q;
	assign start_ev = scl_sy[1] && scl_q && sda_q && !sda_sy[1];
	assign stop_ev = scl_sy[1] && scl_q && !sda_q && sda_sy[1];

	// Strap caught after release, once synchronised
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_s1 <= 7'h00;
			addr_s2 <= 7'h00;
			strap_cnt <= 2'h0;
			own_addr_o <= 7'h00;
		end else begin
			addr_s1 <= bus_addr_i;
			addr_s2 <= addr_s1;
			if (strap_cnt != twrs_pkg::STRAP_DONE_CNT) begin
				strap_cnt <= strap_cnt + 2'h1;
			end
			if (strap_cnt == twrs_pkg::STRAP_LATCH_CNT) begin
				own_addr_o <= addr_s2;
			end
		end
	end

	// Byte engine on synchronised clock edges
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= S_IDLE;
			shreg <= 8'h00;
			tx <= 8'h00;
			bitcnt <= 4'h0;
			ptr <= twrs_pkg::PTR_RESET;
			inhibit <= 1'b0;
			rw <= 1'b0;
			msg_active <= 1'b0;
			resumed <= 1'b0;
			sda_drv <= 1'b0;
			wr_pulse_o <= 1'b0;
			wr_addr_o <= 7'h00;
			wr_data_o <= 8'h00;
		end else begin
			wr_pulse_o <= 1'b0;
			if (stop_ev) begin
				state <= S_IDLE;
				sda_drv <= 1'b0;
				msg_active <= 1'b0;
				if (msg_active) begin
					ptr <= twrs_pkg::PTR_RESET;
					inhibit <= 1'b0;
				end
			end else if (start_ev) begin
				// Pointer kept so a later read resumes there
				state <= S_ADDR;
				bitcnt <= 4'h0;
				sda_drv <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					S_ADDR, S_SUB, S_WDATA: begin
						shreg <= {shreg[6:0], sda_sy[1]};
						bitcnt <= bitcnt + 4'h1;
					end
					S_RDATA: begin
						bitcnt <= bitcnt + 4'h1;
					end
					S_RDATA_ACK: begin
						rw <= sda_sy[1];
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					S_ADDR: begin
						if (bitcnt == twrs_pkg::BITS_PER_BYTE) begin
							if (shreg[7:1] == own_addr_o) begin
								state <= S_ADDR_ACK;
								sda_drv <= 1'b1;
								rw <= shreg[0];
								resumed <= msg_active;
								msg_active <= 1'b1;
							end else begin
								state <= S_IGNORE;
							end
						end
					end
					S_ADDR_ACK: begin
						bitcnt <= 4'h0;
						if (rw) begin
							tx <= regs[ptr];
							sda_drv <= !regs[ptr][7];
							state <= S_RDATA;
						end else begin
							sda_drv <= 1'b0;
							state <= resumed ? S_WDATA : S_SUB;
						end
					end
					S_SUB: begin
						if (bitcnt == twrs_pkg::BITS_PER_BYTE) begin
							ptr <= shreg[6:0];
							inhibit <= shreg[twrs_pkg::INHIBIT_BIT];
							sda_drv <= 1'b1;
							state <= S_SUB_ACK;
						end
					end
					S_WDATA: begin
						if (bitcnt == twrs_pkg::BITS_PER_BYTE) begin
							wr_pulse_o <= 1'b1;
							wr_addr_o <= ptr;
							wr_data_o <= shreg;
							ptr <= next_ptr(ptr, inhibit);
							sda_drv <= 1'b1;
							state <= S_WDATA_ACK;
						end
					end
					S_SUB_ACK, S_WDATA_ACK: begin
						sda_drv <= 1'b0;
						bitcnt <= 4'h0;
						state <= S_WDATA;
					end
					S_RDATA: begin
						if (bitcnt == twrs_pkg::BITS_PER_BYTE) begin
							sda_drv <= 1'b0;
							ptr <= next_ptr(ptr, inhibit);
							state <= S_RDATA_ACK;
						end else begin
							sda_drv <= !tx[3'(4'h7 - bitcnt)];
						end
					end
					S_RDATA_ACK: begin
						bitcnt <= 4'h0;
						if (rw) begin
							// Not acknowledged: last byte, wait for stop
							sda_drv <= 1'b0;
							state <= S_IGNORE;
						end else begin
							tx <= regs[ptr];
							sda_drv <= !regs[ptr][7];
							state <= S_RDATA;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Register file; bytes land one cycle after the ack decision
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < twrs_pkg::REG_COUNT; i++) begin
				regs[i] <= twrs_pkg::REG_RESET;
			end
		end else if (wr_pulse_o) begin
			regs[wr_addr_o] <= wr_data_o;
		end
	end

	assign pass_enable_o = regs[twrs_pkg::TUNER_PORT_ADDR][twrs_pkg::TUNER_PASS_BIT];

	// Pass-through; echo masks stop our own low bouncing back through synchroniser lag
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pull_s <= 1'b0;
			pull_p <= 1'b0;
			echo_hist <= 6'h00;
			link.sscl_d_oe <= 1'b0;
		end else begin
			link.sscl_d_oe <= pass_enable_o && !scl_sy[1];
			pull_s <= pass_enable_o && !sda_sy[1] && !pull_p && !sda_drv && !(|echo_hist[2:0]);
			pull_p <= pass_enable_o && !ssda_sy[1] && !pull_s && !(|echo_hist[5:3]);
			echo_hist <= {echo_hist[4:3], pull_s, echo_hist[1:0], pull_p || sda_drv};
		end
	end

	assign link.ssda_d_oe = pull_s;
	assign link.sda_d_oe = sda_drv || pull_p;
endmodule

// ==== rtl/twrs_master.sv ====
// Two-wire bus master driven by Avalon-MM command and status registers
`timescale 1ns/1ps
module twrs_master(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	twrs_if.master link
);
	typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BYTE} twrs_mstate_type;

	twrs_mstate_type state;
	logic [1:0] sda_sy;
	logic [7:0] tick;
	logic [1:0] qcnt;
	logic [3:0] bitcnt;
	logic [7:0] sh;
	logic [7:0] rx;
	logic rd;
	logic ack_en;
	logic nack;
	logic rvalid;
	logic cmd_take;
	logic [2:0] code;

	assign code = avs_writedata_i[twrs_pkg::CMD_CODE_LSB +: 3];
	// Writes stall while a bus action runs: back-pressure on software
	assign cmd_take = avs_write_i && state == M_IDLE && avs_address_i == twrs_pkg::CMD_OFS;
	assign avs_waitrequest_o = (avs_write_i && state != M_IDLE) || (avs_read_i && !rvalid);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sda_sy <= 2'h3;
		end else begin
			sda_sy <= {sda_sy[0], link.primary_serial_data};
		end
	end

	// Read answer one edge after the request
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rvalid <= 1'b0;
			avs_readdata_o <= 32'h0;
		end else begin
			rvalid <= avs_read_i && !rvalid;
			if (avs_read_i && !rvalid) begin
				avs_readdata_o <= 32'h0;
				if (avs_address_i == twrs_pkg::STAT_OFS) begin
					avs_readdata_o[twrs_pkg::STAT_BUSY_BIT] <= state != M_IDLE;
					avs_readdata_o[twrs_pkg::STAT_NACK_BIT] <= nack;
					avs_readdata_o[twrs_pkg::STAT_DATA_LSB +: 8] <= rx;
				end
			end
		end
	end

	// Quarter-period sequencer for start, stop and nine-bit bytes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= M_IDLE;
			tick <= 8'h00;
			qcnt <= 2'h0;
			bitcnt <= 4'h0;
			sh <= 8'h00;
			rx <= 8'h00;
			rd <= 1'b0;
			ack_en <= 1'b0;
			nack <= 1'b0;
			link.scl_m_oe <= 1'b0;
			link.sda_m_oe <= 1'b0;
		end else if (state == M_IDLE) begin
			tick <= 8'h00;
			qcnt <= 2'h0;
			bitcnt <= 4'h0;
			if (cmd_take) begin
				sh <= avs_writedata_i[twrs_pkg::CMD_DATA_LSB +: 8];
				ack_en <= avs_writedata_i[twrs_pkg::CMD_ACK_BIT];
				rd <= code == twrs_pkg::CMD_READ;
				case (code)
					twrs_pkg::CMD_START: state <= M_START;
					twrs_pkg::CMD_STOP: state <= M_STOP;
					twrs_pkg::CMD_WRITE, twrs_pkg::CMD_READ: state <= M_BYTE;
					default: state <= M_IDLE;
				endcase
			end
		end else begin
			tick <= (tick == twrs_pkg::QUARTER_LAST) ? 8'h00 : tick + 8'h01;
			if (tick == twrs_pkg::QUARTER_LAST) begin
				qcnt <= qcnt + 2'h1;
				if (qcnt == 2'h3) begin
					bitcnt <= bitcnt + 4'h1;
					if (state != M_BYTE || bitcnt == twrs_pkg::BITS_PER_BYTE) begin
						state <= M_IDLE;
					end
				end
			end
			if (tick == 8'h00) begin
				case (state)
					M_START: begin
						case (qcnt)
							2'h0: link.sda_m_oe <= 1'b0;
							2'h1: link.scl_m_oe <= 1'b0;
							2'h2: link.sda_m_oe <= 1'b1;
							default: link.scl_m_oe <= 1'b1;
						endcase
					end
					M_STOP: begin
						case (qcnt)
							2'h0: link.sda_m_oe <= 1'b1;
							2'h1: link.scl_m_oe <= 1'b0;
							2'h2: link.sda_m_oe <= 1'b0;
							default: link.scl_m_oe <= 1'b0;
						endcase
					end
					M_BYTE: begin
						case (qcnt)
							2'h0: begin
								if (bitcnt == twrs_pkg::BITS_PER_BYTE) begin
									link.sda_m_oe <= rd && ack_en;
								end else begin
									link.sda_m_oe <= !rd && !sh[7];
								end
							end
							2'h1: link.scl_m_oe <= 1'b0;
							2'h2: begin
								if (bitcnt == twrs_pkg::BITS_PER_BYTE) begin
									nack <= !rd && sda_sy[1];
									rx <= sh;
								end else begin
									sh <= {sh[6:0], sda_sy[1]};
								end
							end
							default: link.scl_m_oe <= 1'b1;
						endcase
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule

// ==== bench/twrs_properties.sv ====
// Timing checks on the two-wire link and pass-through pins
`timescale 1ns/1ps
module twrs_properties(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic primary_serial_clock,
	input wire logic sda_m_oe,
	input wire logic sda_d_oe,
	input wire logic sscl_d_oe,
	input wire logic ssda_d_oe,
	input wire logic pass_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// Five cycles of history hide the slave's clock synchroniser lag
	a_data_high_stable:
		assert property (primary_serial_clock && $past(primary_serial_clock, 5)
			|-> $stable(sda_d_oe)) else $error("slave data moved in high clock");
	a_drive_in_low:
		assert property ($rose(sda_d_oe) |-> !primary_serial_clock
			&& !$past(primary_serial_clock, 2)) else $error("slave drive began in high clock");
	a_release_in_low:
		assert property ($fell(sda_d_oe) |-> !primary_serial_clock)
			else $error("slave released data in high clock");
	a_ack_stands:
		assert property (sda_d_oe && $rose(primary_serial_clock) |=> sda_d_oe [*8])
			else $error("slave dropped data during high clock");
	a_pass_clock_low:
		assert property (pass_enable_o && $fell(primary_serial_clock) |-> ##[1:4] sscl_d_oe)
			else $error("clock low not passed to tuner");
	a_pass_clock_high:
		assert property (pass_enable_o && $rose(primary_serial_clock) |-> ##[1:4] !sscl_d_oe)
			else $error("tuner clock not released");
	a_pass_data_low:
		assert property (pass_enable_o && $rose(sda_m_oe) |-> ##[1:4] ssda_d_oe)
			else $error("data low not passed to tuner");
	a_pass_closed:
		assert property ((!pass_enable_o) [*5] |-> !sscl_d_oe && !ssda_d_oe)
			else $error("tuner pins driven while port closed");
endmodule

// ==== bench/two_wire_register_slave_tb.sv ====
// Self-checking bench: bus master and register slave joined by the link
`timescale 1ns/1ps
module two_wire_register_slave_tb;
	localparam logic [6:0] DEV = 7'h0E;
	logic clk_i;
	logic resetn_i;
	logic [3:0] av_addr;
	logic av_rd;
	logic av_wr;
	logic [31:0] av_wdata;
	logic [31:0] av_rdata;
	logic av_wait;
	logic pass_en;
	logic wr_pulse;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [6:0] own_addr;
	logic [31:0] stat;
	logic [14:0] wq[$];
	int bad_count;
	int total_checks;

	twrs_if link();
	twrs_master u_twrs_master(.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(av_addr),
		.avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
		.avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait), .link(link.master));
	twrs_device u_twrs_device(.clk_i(clk_i), .resetn_i(resetn_i), .bus_addr_i(DEV),
		.link(link.device), .pass_enable_o(pass_en), .wr_pulse_o(wr_pulse),
		.wr_addr_o(wr_addr), .wr_data_o(wr_data), .own_addr_o(own_addr));
	twrs_properties u_twrs_properties(.clk_i(clk_i), .resetn_i(resetn_i),
		.primary_serial_clock(link.primary_serial_clock), .sda_m_oe(link.sda_m_oe),
		.sda_d_oe(link.sda_d_oe), .sscl_d_oe(link.sscl_d_oe), .ssda_d_oe(link.ssda_d_oe),
		.pass_enable_o(pass_en));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Register writes are caught here so none slips past between checks
	always @(posedge clk_i) begin
		if (wr_pulse === 1'b1)
			wq.push_back({wr_addr, wr_data});
	end

	task automatic stop_test();
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Waits as long as the master holds waitrequest; only the watchdog ends a hang
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		av_addr <= a;
		av_wr <= wr;
		av_rd <= !wr;
		av_wdata <= d;
		do begin
			@(posedge clk_i);
		end while (av_wait !== 1'b0);
		stat = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask

	task automatic cmd(input logic [2:0] code, input logic ack, input logic [7:0] b);
		xfer(1'b1, twrs_pkg::CMD_OFS, {16'h0000, b, 4'h0, ack, code});
		do begin
			xfer(1'b0, twrs_pkg::STAT_OFS, 32'h00000000);
		end while (stat[twrs_pkg::STAT_BUSY_BIT] !== 1'b0);
	endtask

	task automatic wbyte(input logic [7:0] b, input logic nack);
		cmd(twrs_pkg::CMD_WRITE, 1'b0, b);
		check({31'h0, stat[twrs_pkg::STAT_NACK_BIT]}, {31'h0, nack});
	endtask

	task automatic rbyte(input logic ack, input logic [7:0] exp);
		cmd(twrs_pkg::CMD_READ, ack, 8'h00);
		check({24'h0, stat[15:8]}, {24'h0, exp});
	endtask

	task automatic start_addr(input logic rd);
		cmd(twrs_pkg::CMD_START, 1'b0, 8'h00);
		wbyte({DEV, rd}, 1'b0);
	endtask

	task automatic wr_seen(input logic [6:0] a, input logic [7:0] d);
		logic [14:0] e;
		e = 15'h7FFF;
		if (wq.size() != 0)
			e = wq.pop_front();
		check({17'h0, e}, {17'h0, a, d});
	endtask

	// Sized for about 22 bytes of 3600 cycles each plus starts and stops
	initial begin
		repeat (98000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end

	initial begin
		resetn_i = 1'b0;
		av_addr = 4'h0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wdata = 32'h00000000;
		link.ssda_t_oe = 1'b0;
		bad_count = 0;
		total_checks = 0;
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check({25'h0, own_addr}, {25'h0, DEV});
		xfer(1'b0, 4'h8, 32'h00000000);
		check(stat, 32'h00000000);
		start_addr(1'b0);
		wbyte(8'h00, 1'b0);
		wbyte(8'hA5, 1'b0);
		wbyte(8'h3C, 1'b0);
		cmd(twrs_pkg::CMD_STOP, 1'b0, 8'h00);
		wr_seen(7'h00, 8'hA5);
		wr_seen(7'h01, 8'h3C);
		start_addr(1'b0);
		wbyte(8'h01, 1'b0);
		start_addr(1'b1);
		rbyte(1'b1, 8'h3C);
		rbyte(1'b0, 8'h00);
		cmd(twrs_pkg::CMD_STOP, 1'b0, 8'h00);
		start_addr(1'b1);
		rbyte(1'b1, 8'hA5);
		rbyte(1'b0, 8'h3C);
		cmd(twrs_pkg::CMD_STOP, 1'b0, 8'h00);
		start_addr(1'b0);
		wbyte(8'h94, 1'b0);
		wbyte(8'h40, 1'b0);
		check({31'h0, pass_en}, 32'h00000001);
		start_addr(1'b0);
		wbyte(8'h00, 1'b0);
		cmd(twrs_pkg::CMD_STOP, 1'b0, 8'h00);
		wr_seen(7'h14, 8'h40);
		wr_seen(7'h14, 8'h00);
		check({31'h0, pass_en}, 32'h00000000);
		start_addr(1'b0);
		wbyte(8'h7F, 1'b0);
		wbyte(8'h11, 1'b0);
		wbyte(8'h22, 1'b0);
		cmd(twrs_pkg::CMD_STOP, 1'b0, 8'h00);
		wr_seen(7'h7F, 8'h11);
		wr_seen(7'h7F, 8'h22);
		cmd(twrs_pkg::CMD_START, 1'b0, 8'h00);
		wbyte({DEV ^ 7'h01, 1'b0}, 1'b1);
		cmd(twrs_pkg::CMD_STOP, 1'b0, 8'h00);
		check(wq.size(), 32'h00000000);
		stop_test();
	end
endmodule
